// ---- core/cssp_defines.svh ----
// offsets, field positions and reset values of the socket status and power registers
`ifndef CSSP_DEFINES_SVH
`define CSSP_DEFINES_SVH
`define CSSP_PORT_INDEX 1'h0
`define CSSP_PORT_DATA 1'h1
`define CSSP_IDX_REVISION 6'h00
`define CSSP_IDX_STATUS 6'h01
`define CSSP_IDX_POWER 6'h02
`define CSSP_IDX_SOCKET_BIT 6
`define CSSP_IDX_RSVD_BIT 7
`define CSSP_REV_IFACE_MEM_IO 2'h2
// stepping value is arbitrary, not a real part's code
`define CSSP_REV_STEPPING 4'h5
`define CSSP_STAT_ALWAYS_ONE 1'h1
`define CSSP_PWR_CARD_EN_BIT 7
`define CSSP_PWR_AUTO_BIT 5
`define CSSP_PWR_VCC_BIT 4
`define CSSP_PWR_RESET 8'h00
`define CSSP_INDEX_RESET 8'h00
`define CSSP_RDATA_RESET 8'h00
`define CSSP_UNMAPPED_READ 8'h00
`endif

// ---- core/cssp_pkg.sv ----
// types shared by the socket status and power register bank
package cssp_pkg;
  typedef logic [7:0] cssp_byte_t;
  typedef enum logic [1:0] {
    CSSP_VPP_ZERO = 2'h0,
    CSSP_VPP_VCC = 2'h1,
    CSSP_VPP_TWELVE = 2'h2,
    CSSP_VPP_ZERO_ALT = 2'h3
  } cssp_vpp_sel_t;
endpackage : cssp_pkg

// ---- core/cssp_regs.sv ----
// index/data register bank: revision, per-socket status and power control
// Function
// [R1] data port reaches register chosen by index
// [R2] interface type field reads memory plus I/O
// [R3] fixed four-bit stepping code in bits 3-0
// [R4] revision bits 5-4 always read zero
// [R5] status bit 7 always reads one
// [R6] status bits 3-2 are inverted detect pins
// [R7] status bit 5 shows ready pin level
// [R8] status bit 4 shows write-protect pin
// [R9] status bits 1-0 show battery status pins; bit 1 reads zero in I/O mode
// [R10] status bit 6 shows card power on
// [R11] power off: supplies inactive, programming selects low
// [R12] auto-power gates supplies on card detect
// [R13] programming field selects zero, card supply, twelve
// [R14] socket outputs float unless enabled and seated
// [R15] card removal clears supply enable unless disabled
`timescale 1ns/1ns
`include "cssp_defines.svh"
module cssp_regs (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire cssp_pkg::cssp_byte_t bus_wdata_i,
  output cssp_pkg::cssp_byte_t bus_rdata_o,
  input wire logic [1:0] card_ready_irq_pin_i,
  input wire logic [1:0] write_protect_pin_i,
  input wire logic [1:0] card_detect_a_n_i,
  input wire logic [1:0] card_detect_b_n_i,
  input wire logic [1:0] battery_status_a_pin_i,
  input wire logic [1:0] battery_status_b_pin_i,
  input wire logic [1:0] card_is_io_i,
  input wire logic [1:0] vcc_3v3_sel_i,
  input wire logic [1:0] auto_off_disable_i,
  input wire logic [1:0] vcc_write_lock_i,
  output logic [1:0] vcc_3v3_n_o,
  output logic [1:0] vcc_5v_n_o,
  output logic [1:0] prog_supply_twelve_select_o,
  output logic [1:0] prog_supply_vcc_select_o,
  output logic [1:0] socket_out_oe_n_o
);
  import cssp_pkg::*;
  cssp_byte_t index_reg;
  cssp_byte_t index_next;
  cssp_byte_t rdata_reg;
  cssp_byte_t rdata_next;
  cssp_byte_t chip_revision_id;
  cssp_byte_t socket_interface_status [2];
  cssp_byte_t socket_power_control [2];
  logic sel_socket;
  logic idx_mapped;

  assign sel_socket = index_reg[`CSSP_IDX_SOCKET_BIT];
  assign idx_mapped = ~index_reg[`CSSP_IDX_RSVD_BIT];
  // reserved bits are constant zero, writes cannot reach them
  assign chip_revision_id = {`CSSP_REV_IFACE_MEM_IO, 2'h0, `CSSP_REV_STEPPING}; // see [R2] see [R3] see [R4]

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      logic [5:0] pins;
      logic inserted;
      logic removed;
      logic wr_hit;
      logic pwr_on;
      cssp_byte_t pwr_reg;
      cssp_byte_t pwr_next;
      logic [4:0] out_reg;
      logic [4:0] out_next;
      logic stat_pwr_reg;
      logic stat_pwr_next;

      cssp_socket_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pins_i({card_ready_irq_pin_i[s], write_protect_pin_i[s], card_detect_b_n_i[s],
                 card_detect_a_n_i[s], battery_status_b_pin_i[s], battery_status_a_pin_i[s]}),
        .pins_o(pins),
        .inserted_o(inserted),
        .removed_o(removed)
      );

      assign wr_hit = bus_wr_i & (bus_addr_i == `CSSP_PORT_DATA) & idx_mapped
                      & (sel_socket == s[0]) & (index_reg[5:0] == `CSSP_IDX_POWER); // see [R1]
      assign pwr_on = pwr_reg[`CSSP_PWR_VCC_BIT] & (~pwr_reg[`CSSP_PWR_AUTO_BIT] | inserted); // see [R12]

      always_comb begin
        pwr_next = pwr_reg;
        // removal drops supply enable; a write in the same cycle still wins
        if (removed && !auto_off_disable_i[s]) begin
          pwr_next[`CSSP_PWR_VCC_BIT] = 1'b0; // see [R15]
        end
        if (wr_hit) begin
          pwr_next = bus_wdata_i;
          if (vcc_write_lock_i[s]) begin
            pwr_next[`CSSP_PWR_VCC_BIT] = pwr_reg[`CSSP_PWR_VCC_BIT];
          end
        end
        stat_pwr_next = pwr_on; // see [R10]
        // order: vcc3_n, vcc5_n, twelve, vcc_sel, oe_n
        out_next[0] = ~(pwr_on & vcc_3v3_sel_i[s]); // see [R11]
        out_next[1] = ~(pwr_on & ~vcc_3v3_sel_i[s]); // see [R11]
        out_next[2] = pwr_on & (cssp_vpp_sel_t'(pwr_reg[1:0]) == CSSP_VPP_TWELVE); // see [R13]
        out_next[3] = pwr_on & (cssp_vpp_sel_t'(pwr_reg[1:0]) == CSSP_VPP_VCC); // see [R13]
        // supply enable deliberately does not gate the outputs
        out_next[4] = ~(inserted & pwr_reg[`CSSP_PWR_CARD_EN_BIT]); // see [R14]
      end

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          pwr_reg <= `CSSP_PWR_RESET;
          out_reg <= 5'h13; // see [R11]
          stat_pwr_reg <= 1'b0;
        end else begin
          pwr_reg <= pwr_next;
          out_reg <= out_next;
          stat_pwr_reg <= stat_pwr_next;
        end
      end

      assign socket_power_control[s] = pwr_reg;
      // ready and write-protect pass raw in I/O mode, where software ignores them
      assign socket_interface_status[s] = {`CSSP_STAT_ALWAYS_ONE, stat_pwr_reg, pins[5], pins[4], // see [R5] see [R7] see [R8]
                                           ~pins[3], ~pins[2], // see [R6]
                                           pins[1] & ~card_is_io_i[s], pins[0]}; // see [R9]
      assign vcc_3v3_n_o[s] = out_reg[0];
      assign vcc_5v_n_o[s] = out_reg[1];
      assign prog_supply_twelve_select_o[s] = out_reg[2];
      assign prog_supply_vcc_select_o[s] = out_reg[3];
      assign socket_out_oe_n_o[s] = out_reg[4];
    end
  endgenerate

  always_comb begin
    index_next = index_reg;
    rdata_next = rdata_reg;
    if (bus_wr_i && bus_addr_i == `CSSP_PORT_INDEX) begin
      index_next = bus_wdata_i;
    end
    if (bus_rd_i) begin
      if (bus_addr_i == `CSSP_PORT_INDEX) begin
        rdata_next = index_reg;
      end else if (!idx_mapped) begin
        rdata_next = `CSSP_UNMAPPED_READ;
      end else if (index_reg[5:0] == `CSSP_IDX_REVISION) begin
        rdata_next = chip_revision_id; // see [R1]
      end else if (index_reg[5:0] == `CSSP_IDX_STATUS) begin
        rdata_next = socket_interface_status[sel_socket]; // see [R1]
      end else if (index_reg[5:0] == `CSSP_IDX_POWER) begin
        rdata_next = socket_power_control[sel_socket]; // see [R1]
      end else begin
        rdata_next = `CSSP_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      index_reg <= `CSSP_INDEX_RESET;
      rdata_reg <= `CSSP_RDATA_RESET;
    end else begin
      index_reg <= index_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata_o = rdata_reg;
endmodule : cssp_regs

// ---- core/cssp_socket_sync.sv ----
// pin synchroniser and insertion detector for one card socket
`timescale 1ns/1ns
module cssp_socket_sync (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] pins_i,
  output logic [5:0] pins_o,
  output logic inserted_o,
  output logic removed_o
);
  import cssp_pkg::*;
  logic [5:0] meta_reg;
  logic [5:0] meta_next;
  logic [5:0] sync_reg;
  logic [5:0] sync_next;
  logic ins_reg;
  logic ins_next;
  logic rem_reg;
  logic rem_next;

  always_comb begin
    meta_next = pins_i;
    sync_next = meta_reg;
    // pins [3:2] are the two active-low detects; both low means fully seated
    ins_next = ~sync_reg[3] & ~sync_reg[2];
    rem_next = ins_reg & ~ins_next;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // detects idle high, so no false insertion right after reset
      meta_reg <= 6'h0c;
      sync_reg <= 6'h0c;
      ins_reg <= 1'b0;
      rem_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      ins_reg <= ins_next;
      rem_reg <= rem_next;
    end
  end

  assign pins_o = sync_reg;
  assign inserted_o = ins_reg;
  assign removed_o = rem_reg;
endmodule : cssp_socket_sync

// ---- tb/cssp_card_model.sv ----
// card model driving the pins of both sockets
`timescale 1ns/1ns
module cssp_card_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] seat_i,
  input wire logic [1:0] half_i,
  input wire logic [3:0] lvl_i,
  output logic [1:0] rdy_o,
  output logic [1:0] wp_o,
  output logic [1:0] cda_n_o,
  output logic [1:0] cdb_n_o,
  output logic [1:0] bva_o,
  output logic [1:0] bvb_o
);
  logic tog = 1'b0;
  logic [1:0] on;
  always @(posedge ref_clk_i) tog <= !tog;
  assign on = seat_i | half_i;
  // detect pins pulled up when absent; half seated grounds one only
  assign cda_n_o = ~on;
  assign cdb_n_o = ~seat_i;
  // absent card floats its lines: toggle so no stale level passes
  assign rdy_o = on & {2{lvl_i[3]}} | ~on & {2{tog}};
  assign wp_o = on & {2{lvl_i[2]}} | ~on & {2{tog}};
  assign bvb_o = on & {2{lvl_i[1]}} | ~on & {2{tog}};
  assign bva_o = on & {2{lvl_i[0]}} | ~on & {2{!tog}};
endmodule : cssp_card_model

// ---- tb/cssp_regs_props.sv ----
// checker for the socket status and power register bank
`timescale 1ns/1ns
module cssp_regs_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic [1:0] card_detect_a_n_i,
  input wire logic [1:0] vcc_3v3_n_o,
  input wire logic [1:0] vcc_5v_n_o,
  input wire logic [1:0] prog_supply_twelve_select_o,
  input wire logic [1:0] prog_supply_vcc_select_o,
  input wire logic [1:0] socket_out_oe_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_idx(v);
    bus_wr_i && !bus_addr_i && bus_wdata_i == v ##1 !bus_wr_i ##1 bus_rd_i && bus_addr_i;
  endsequence
  a_rev_type_read: assert property (rd_idx(8'h00) |=> bus_rdata_o[7:4] == 4'h8)
    else $error("revision type or reserved bits wrong");
  a_stat_top_one: assert property (rd_idx(8'h01) |=> bus_rdata_o[7])
    else $error("status bit 7 not one");
  a_rdata_holds: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data changed without read");
  a_reset_pwr_off: assert property (disable iff (1'b0) rst_i |=> &vcc_3v3_n_o && &vcc_5v_n_o
    && prog_supply_twelve_select_o == 2'b00 && prog_supply_vcc_select_o == 2'b00)
    else $error("supplies active in reset");
  a_reset_float: assert property (disable iff (1'b0) rst_i |=> &socket_out_oe_n_o)
    else $error("socket outputs driven in reset");
  // programming supply follows card supply, never alone
  a_prog_needs_vcc: assert property ((vcc_3v3_n_o & vcc_5v_n_o
    & (prog_supply_twelve_select_o | prog_supply_vcc_select_o)) == 2'b00)
    else $error("programming supply on while power off");
  a_prog_one_sel: assert property ((prog_supply_twelve_select_o & prog_supply_vcc_select_o) == 2'b00)
    else $error("both programming selects high");
  a_float_absent: assert property (card_detect_a_n_i[0] [*8] |-> socket_out_oe_n_o[0])
    else $error("outputs driven with card absent");
  c_rev_read: cover property (rd_idx(8'h00));
  c_out_on: cover property (!socket_out_oe_n_o[0]);
  c_twelve: cover property (prog_supply_twelve_select_o[0]);
endmodule : cssp_regs_props
bind cssp_regs cssp_regs_props u_cssp_regs_props (.*);

// ---- tb/cssp_regs_tb.sv ----
// self-checking bench of the socket register bank
`timescale 1ns/1ns
`include "cssp_defines.svh"
module cssp_regs_tb;
  import cssp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic a = 1'b0, wr = 1'b0, rd = 1'b0;
  cssp_byte_t wd = 8'h00;
  cssp_byte_t rdat;
  logic [1:0] seat = 2'b00, half = 2'b00, io = 2'b00;
  logic [1:0] rdy, wp, cda, cdb, bva, bvb, v3, v5, p12, pvc, oe;
  int errors = 0, compares = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  cssp_card_model u_cssp_card_model (.ref_clk_i(ref_clk_i), .seat_i(seat), .half_i(half), .lvl_i(4'b1010),
    .rdy_o(rdy), .wp_o(wp), .cda_n_o(cda), .cdb_n_o(cdb), .bva_o(bva), .bvb_o(bvb));
  cssp_regs u_cssp_regs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_addr_i(a), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_wdata_i(wd), .bus_rdata_o(rdat), .card_ready_irq_pin_i(rdy), .write_protect_pin_i(wp),
    .card_detect_a_n_i(cda), .card_detect_b_n_i(cdb), .battery_status_a_pin_i(bva),
    .battery_status_b_pin_i(bvb), .card_is_io_i(io), .vcc_3v3_sel_i(2'b00), .auto_off_disable_i(2'b00),
    .vcc_write_lock_i(2'b00), .vcc_3v3_n_o(v3), .vcc_5v_n_o(v5), .prog_supply_twelve_select_o(p12),
    .prog_supply_vcc_select_o(pvc), .socket_out_oe_n_o(oe));
  task automatic chk(input string n, input cssp_byte_t s, input cssp_byte_t e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic ad, input logic w, input cssp_byte_t d);
    @(posedge ref_clk_i);
    a <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  task automatic rreg(input cssp_byte_t i, input cssp_byte_t e, input string n);
    acc(1'b0, 1'b1, i);
    acc(1'b1, 1'b0, 8'h00);
    @(posedge ref_clk_i);
    #1 chk(n, rdat, e);
  endtask : rreg
  // settle time covers pin sync and output registers
  task automatic wreg(input cssp_byte_t i, input cssp_byte_t d);
    acc(1'b0, 1'b1, i);
    acc(1'b1, 1'b1, d);
    repeat (8) @(posedge ref_clk_i);
  endtask : wreg
  task automatic pins(input logic [1:0] s, input logic [1:0] h);
    @(posedge ref_clk_i);
    seat <= s;
    half <= h;
    repeat (8) @(posedge ref_clk_i);
  endtask : pins
  // socket a outputs packed as {3v3_n, 5v_n, twelve, vcc, oe_n}
  task automatic outs(input cssp_byte_t e, input string n);
    #1 chk(n, {3'b000, v3[0], v5[0], p12[0], pvc[0], oe[0]}, e);
  endtask : outs
  task automatic t_rev();
    rreg(8'h00, {4'h8, `CSSP_REV_STEPPING}, "rev a");
    wreg(8'h40, 8'hff);
    rreg(8'h40, {4'h8, `CSSP_REV_STEPPING}, "rev b");
  endtask : t_rev
  task automatic t_stat();
    pins(2'b11, 2'b00);
    rreg(8'h01, 8'hae, "stat a");
    io <= 2'b10;
    rreg(8'h41, 8'hac, "stat b io");
    pins(2'b00, 2'b01);
    rreg(8'h01, 8'ha6, "stat half");
    pins(2'b00, 2'b00);
  endtask : t_stat
  task automatic t_pwr();
    wreg(8'h02, 8'h13);
    outs(8'h11, "no auto");
    pins(2'b11, 2'b00);
    wreg(8'h02, 8'h92);
    outs(8'h14, "twelve");
    rreg(8'h01, 8'hee, "pwr on");
    wreg(8'h02, 8'hb1);
    outs(8'h12, "vcc pgm");
    pins(2'b00, 2'b00);
    outs(8'h19, "removed");
    rreg(8'h02, 8'ha1, "auto off");
  endtask : t_pwr
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    outs(8'h19, "reset");
    t_rev();
    t_stat();
    t_pwr();
    results();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    results();
  end
  task automatic results();
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
endmodule : cssp_regs_tb
